// *** logic/lbt_pkg.sv ***
// constants and types for the loop, branch and threaded-code execution block
// Behaviour
// RULE1: divide treats 16-bit dividend and 8-bit divisor as unsigned values.
// RULE2: remainder goes to the even (upper) byte, quotient to the odd byte.
// RULE3: loop-branch decrements the register and branches when the result is nonzero.
// RULE4: loop-branch displacement is signed 8-bit, reaching +127 to -128.
// RULE5: branch base is the address after the two-byte instruction.
// RULE6: loop-branch is two bytes, 8 cycles either way, register in upper nibble.
// RULE7: software should keep the loop counter register in 0C0H to 0CFH.
// RULE8: loop-branch, interrupt-enable, enter and exit leave flags unchanged.
// RULE9: interrupt-enable sets system mode bit 0, the global interrupt enable.
// RULE10: interrupts pending while disabled are serviced once enable is set again.
// RULE11: enter lowers the stack pointer by 2, then pushes the instruction pointer.
// RULE12: enter then copies the program counter into the instruction pointer.
// RULE13: enter loads PC from program word at pointer, then adds 2 to pointer.
// RULE14: exit pops the instruction pointer, then raises the stack pointer by 2.
// RULE15: exit loads PC from program word at pointer, then adds 2 to pointer.
// RULE16: sixteen-bit words are assembled with the high byte at the lower address.
package lbt_pkg;
    localparam logic [7:0] OP_DIV_R = 8'h94;
    localparam logic [7:0] OP_DIV_IR = 8'h95;
    localparam logic [7:0] OP_DIV_IM = 8'h96;
    localparam logic [3:0] OP_LOOP_LOW = 4'ha;
    localparam logic [7:0] OP_INT_EN = 8'h9f;
    localparam logic [7:0] OP_ENTER = 8'h1f;
    localparam logic [7:0] OP_EXIT = 8'h2f;
    localparam int LOOP_CYCLES = 8;
    localparam int LOOP_BYTES = 2;
    localparam int DIV_CYCLES = 26;
    localparam int DIV_ZERO_CYCLES = 10;
    localparam int THREAD_CYCLES = 14;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam int GIE_BIT = 0;
    localparam logic [7:0] SYSMODE_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] IPTR_RESET = 16'h0000;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DIV = 4'h1,
        ST_LOOP = 4'h2,
        ST_EN_PUSH_HI = 4'h3,
        ST_EN_PUSH_LO = 4'h4,
        ST_FETCH_HI = 4'h5,
        ST_FETCH_LO = 4'h6,
        ST_EX_POP_HI = 4'h7,
        ST_EX_POP_LO = 4'h8,
        ST_PAD = 4'h9
    } lbt_state_e;
endpackage

// *** logic/lbt_divider.sv ***
// restoring unsigned divider, one quotient bit per step
`timescale 1ns/1ns
module lbt_divider #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [2*W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [W-1:0] quotient,
    output logic [W-1:0] remainder
);
    initial begin
        if (W < 2) $error("lbt_divider width too small");
    end
    logic [2*W-1:0] quo_acc;
    logic [W:0] rem_acc;
    logic [$clog2(2*W+1)-1:0] step;
    // unsigned trial subtraction [RULE1]
    wire [W+1:0] shifted = {rem_acc, quo_acc[2*W-1]};
    wire [W+1:0] trial = shifted - {2'b00, divisor};
    wire fits = !trial[W+1];
    wire last = (step == 1);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            quo_acc <= '0;
            rem_acc <= '0;
            step <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
            remainder <= '0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy) begin
                quo_acc <= dividend;
                rem_acc <= '0;
                step <= ($clog2(2*W+1))'(2*W);
                busy <= 1'b1;
            end else if (busy) begin
                rem_acc <= fits ? trial[W:0] : shifted[W:0];
                quo_acc <= {quo_acc[2*W-2:0], fits};
                step <= step - 1'b1;
                if (last) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= {quo_acc[W-2:0], fits};
                    remainder <= fits ? trial[W-1:0] : shifted[W-1:0];
                end
            end
        end
    end
endmodule

// *** logic/lbt_exec.sv ***
// execution unit for divide, loop-branch, interrupt-enable, enter and exit
`timescale 1ns/1ns
module lbt_exec (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] div_dividend,
    input wire logic [7:0] div_divisor,
    input wire logic [7:0] loop_reg_val,
    input wire logic [7:0] pmem_rdata,
    input wire logic [7:0] stack_rdata,
    input wire logic int_pending,
    output logic busy,
    output logic done,
    output logic reg_we,
    output logic [3:0] reg_waddr,
    output logic [7:0] reg_wdata,
    output logic pair_we,
    output logic [7:0] pair_even_data,
    output logic [7:0] pair_odd_data,
    output logic pc_we,
    output logic [15:0] pc_out,
    output logic [15:0] sp,
    output logic [15:0] instruction_pointer,
    output logic [7:0] system_mode_register,
    output logic pmem_re,
    output logic [15:0] pmem_addr,
    output logic stack_we,
    output logic stack_re,
    output logic [15:0] stack_addr,
    output logic [7:0] stack_wdata,
    output logic flags_we,
    output logic int_service
);
    lbt_pkg::lbt_state_e state;
    logic [4:0] cnt;
    logic [7:0] hi_byte;
    logic is_enter;
    logic [3:0] loop_reg;
    logic [15:0] loop_target;
    logic loop_take;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [7:0] div_q;
    logic [7:0] div_r;
    // ******************************
    // decode
    // ******************************
    wire dec_div = (opcode == lbt_pkg::OP_DIV_R) || (opcode == lbt_pkg::OP_DIV_IR)
        || (opcode == lbt_pkg::OP_DIV_IM);
    wire dec_loop = opcode[3:0] == lbt_pkg::OP_LOOP_LOW; // [RULE6]
    wire dec_ie = opcode == lbt_pkg::OP_INT_EN;
    wire dec_enter = opcode == lbt_pkg::OP_ENTER;
    wire dec_exit = opcode == lbt_pkg::OP_EXIT;
    wire idle = state == lbt_pkg::ST_IDLE;
    wire go = clk_en && idle && op_valid;
    wire [7:0] loop_dec = loop_reg_val - 8'h01; // [RULE3]
    // signed displacement on the following-byte base [RULE4] [RULE5]
    wire [15:0] loop_base = pc_in + 16'(lbt_pkg::LOOP_BYTES);
    wire [15:0] loop_dest = loop_base + {{8{operand[7]}}, operand};
    wire [15:0] sp_down = sp - lbt_pkg::WORD_STEP;
    wire div_zero = div_divisor == 8'h00;
    wire [15:0] ip_next = instruction_pointer + lbt_pkg::WORD_STEP;
    lbt_divider #(.W(8)) u_div (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .start(div_start),
        .dividend(div_dividend),
        .divisor(div_divisor),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q),
        .remainder(div_r)
    );
    // ******************************
    // sequencer
    // ******************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= lbt_pkg::ST_IDLE;
            cnt <= '0;
            hi_byte <= '0;
            is_enter <= 1'b0;
            loop_reg <= '0;
            loop_target <= '0;
            loop_take <= 1'b0;
            div_start <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            reg_we <= 1'b0;
            reg_waddr <= '0;
            reg_wdata <= '0;
            pair_we <= 1'b0;
            pair_even_data <= '0;
            pair_odd_data <= '0;
            pc_we <= 1'b0;
            pc_out <= lbt_pkg::PC_RESET;
            sp <= lbt_pkg::SP_RESET;
            instruction_pointer <= lbt_pkg::IPTR_RESET;
            system_mode_register <= lbt_pkg::SYSMODE_RESET;
            pmem_re <= 1'b0;
            pmem_addr <= '0;
            stack_we <= 1'b0;
            stack_re <= 1'b0;
            stack_addr <= '0;
            stack_wdata <= '0;
            flags_we <= 1'b0;
            int_service <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            reg_we <= 1'b0;
            pair_we <= 1'b0;
            pc_we <= 1'b0;
            pmem_re <= 1'b0;
            stack_we <= 1'b0;
            stack_re <= 1'b0;
            div_start <= 1'b0;
            flags_we <= 1'b0; // [RULE8]
            // pending request is honoured while enable is set and the sequencer is idle [RULE10]
            int_service <= int_pending && system_mode_register[lbt_pkg::GIE_BIT] && idle;
            unique case (state)
                lbt_pkg::ST_IDLE: begin
                    if (go && dec_div) begin
                        busy <= 1'b1;
                        div_start <= !div_zero;
                        cnt <= 5'(div_zero ? lbt_pkg::DIV_ZERO_CYCLES - 2 : 0);
                        state <= div_zero ? lbt_pkg::ST_PAD : lbt_pkg::ST_DIV;
                    end else if (go && dec_loop) begin
                        busy <= 1'b1;
                        loop_reg <= opcode[7:4];
                        loop_take <= loop_dec != 8'h00;
                        loop_target <= loop_dest;
                        reg_wdata <= loop_dec;
                        cnt <= 5'(lbt_pkg::LOOP_CYCLES - 2);
                        state <= lbt_pkg::ST_LOOP;
                    end else if (go && dec_ie) begin
                        system_mode_register[lbt_pkg::GIE_BIT] <= 1'b1; // [RULE9]
                        done <= 1'b1;
                    end else if (go && dec_enter) begin
                        busy <= 1'b1;
                        is_enter <= 1'b1;
                        sp <= sp_down; // [RULE11]
                        stack_addr <= sp_down;
                        stack_wdata <= instruction_pointer[15:8];
                        stack_we <= 1'b1;
                        state <= lbt_pkg::ST_EN_PUSH_HI;
                    end else if (go && dec_exit) begin
                        busy <= 1'b1;
                        is_enter <= 1'b0;
                        stack_addr <= sp; // [RULE14]
                        stack_re <= 1'b1;
                        state <= lbt_pkg::ST_EX_POP_HI;
                    end else if (go) begin
                        done <= 1'b1;
                    end
                end
                lbt_pkg::ST_DIV: begin
                    if (div_done) begin
                        pair_we <= 1'b1;
                        pair_even_data <= div_r; // [RULE2]
                        pair_odd_data <= div_q;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= lbt_pkg::ST_IDLE;
                    end
                end
                lbt_pkg::ST_LOOP: begin
                    if (cnt == 5'(lbt_pkg::LOOP_CYCLES - 2)) begin
                        reg_we <= 1'b1; // [RULE3]
                        reg_waddr <= loop_reg;
                    end
                    if (cnt == '0) begin
                        pc_we <= 1'b1;
                        pc_out <= loop_take ? loop_target : pc_in + 16'(lbt_pkg::LOOP_BYTES);
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= lbt_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                lbt_pkg::ST_EN_PUSH_HI: begin
                    // high byte at lower address [RULE16]
                    stack_addr <= stack_addr + 16'h0001;
                    stack_wdata <= instruction_pointer[7:0];
                    stack_we <= 1'b1;
                    state <= lbt_pkg::ST_EN_PUSH_LO;
                end
                lbt_pkg::ST_EN_PUSH_LO: begin
                    instruction_pointer <= pc_in; // [RULE12]
                    pmem_addr <= pc_in;
                    pmem_re <= 1'b1;
                    state <= lbt_pkg::ST_FETCH_HI;
                end
                lbt_pkg::ST_EX_POP_HI: begin
                    hi_byte <= stack_rdata; // [RULE16]
                    stack_addr <= stack_addr + 16'h0001;
                    stack_re <= 1'b1;
                    state <= lbt_pkg::ST_EX_POP_LO;
                end
                lbt_pkg::ST_EX_POP_LO: begin
                    instruction_pointer <= {hi_byte, stack_rdata}; // [RULE14]
                    sp <= sp + lbt_pkg::WORD_STEP;
                    pmem_addr <= {hi_byte, stack_rdata};
                    pmem_re <= 1'b1;
                    state <= lbt_pkg::ST_FETCH_HI;
                end
                lbt_pkg::ST_FETCH_HI: begin
                    hi_byte <= pmem_rdata; // [RULE16]
                    pmem_addr <= pmem_addr + 16'h0001;
                    pmem_re <= 1'b1;
                    state <= lbt_pkg::ST_FETCH_LO;
                end
                lbt_pkg::ST_FETCH_LO: begin
                    pc_out <= {hi_byte, pmem_rdata}; // [RULE13] [RULE15]
                    pc_we <= 1'b1;
                    instruction_pointer <= ip_next;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= lbt_pkg::ST_IDLE;
                end
                lbt_pkg::ST_PAD: begin
                    if (cnt == '0) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= lbt_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                default: begin
                    busy <= 1'b0;
                    state <= lbt_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** dv/lbt_exec_monitor.sv ***
// port assertions for the execution unit
`timescale 1ns/1ns
module lbt_exec_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] div_dividend,
    input wire logic [7:0] div_divisor,
    input wire logic [7:0] loop_reg_val,
    input wire logic int_pending,
    input wire logic busy,
    input wire logic done,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    input wire logic pair_we,
    input wire logic [7:0] pair_even_data,
    input wire logic [7:0] pair_odd_data,
    input wire logic pc_we,
    input wire logic [15:0] pc_out,
    input wire logic [15:0] sp,
    input wire logic [15:0] instruction_pointer,
    input wire logic [7:0] system_mode_register,
    input wire logic pmem_re,
    input wire logic [15:0] pmem_addr,
    input wire logic stack_we,
    input wire logic flags_we,
    input wire logic int_service
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic take = clk_en && op_valid && !busy;
    wire logic take_loop = take && (opcode[3:0] == lbt_pkg::OP_LOOP_LOW);
    wire logic take_enter = take && (opcode == lbt_pkg::OP_ENTER);
    wire logic take_exit = take && (opcode == lbt_pkg::OP_EXIT);
    wire logic [15:0] disp = {{8{operand[7]}}, operand};
    wire logic no_ovf = div_dividend[15:8] < div_divisor;
    wire logic [15:0] quo = div_dividend / {8'h00, div_divisor};
    wire logic [15:0] rem = div_dividend % {8'h00, div_divisor};
    flags_untouched_a: assert property (!flags_we)
        else $error("flag write seen");
    loop_decrement_a: assert property (take_loop |-> ##2 reg_we && reg_wdata == $past(loop_reg_val, 2) - 8'h01)
        else $error("counter write wrong");
    loop_target_a: assert property (take_loop |-> ##8 done && pc_we && pc_out == $past(pc_in, 8) + 16'h0002 + (($past(loop_reg_val, 8) == 8'h01) ? 16'h0000 : $past(disp, 8)))
        else $error("loop target wrong");
    int_enable_a: assert property (take && opcode == lbt_pkg::OP_INT_EN |=> done && system_mode_register[0])
        else $error("global enable not set");
    int_service_a: assert property (clk_en && int_pending && system_mode_register[0] && !busy |=> int_service)
        else $error("pending interrupt not serviced");
    enter_push_a: assert property (take_enter |=> stack_we && sp == $past(sp) - lbt_pkg::WORD_STEP)
        else $error("enter push wrong");
    enter_load_a: assert property (take_enter |-> ##3 pmem_re && pmem_addr == $past(pc_in, 3) && instruction_pointer == $past(pc_in, 3) ##2 done && pc_we && instruction_pointer == $past(pc_in, 5) + 16'h0002)
        else $error("enter load wrong");
    exit_pop_a: assert property (take_exit |-> ##3 sp == $past(sp, 3) + 16'h0002 && pmem_re && pmem_addr == instruction_pointer ##2 done && pc_we && instruction_pointer == $past(instruction_pointer, 2) + 16'h0002)
        else $error("exit pop wrong");
    divide_pair_a: assert property (pair_we && no_ovf |-> pair_even_data == rem[7:0] && pair_odd_data == quo[7:0])
        else $error("divide pair wrong");
endmodule

// *** dv/loop_branch_thread_ops_test.sv ***
// self-checking bench for the execution unit
`timescale 1ns/1ns
module loop_branch_thread_ops_test;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic op_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] operand = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    logic [15:0] div_dividend = 16'h0000;
    logic [7:0] div_divisor = 8'h00;
    logic [7:0] loop_reg_val = 8'h00;
    logic [7:0] pmem_rdata;
    logic [7:0] stack_rdata;
    logic int_pending = 1'b0;
    logic busy, done, reg_we, pair_we, pc_we, pmem_re, stack_we, stack_re, flags_we, int_service;
    logic [3:0] reg_waddr;
    logic [7:0] reg_wdata, pair_even_data, pair_odd_data, system_mode_register, stack_wdata;
    logic [15:0] pc_out, sp, instruction_pointer, pmem_addr, stack_addr;
    logic [7:0] stack_mem [0:255];
    logic got_pair;
    logic [7:0] seen_even, seen_odd, seen_reg;
    int num_errors = 0;
    int comparisons = 0;
    int n;
    always #25 clock = ~clock;
    lbt_exec dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .op_valid(op_valid),
        .opcode(opcode), .operand(operand), .pc_in(pc_in), .div_dividend(div_dividend),
        .div_divisor(div_divisor), .loop_reg_val(loop_reg_val), .pmem_rdata(pmem_rdata),
        .stack_rdata(stack_rdata), .int_pending(int_pending), .busy(busy), .done(done),
        .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .pair_we(pair_we),
        .pair_even_data(pair_even_data), .pair_odd_data(pair_odd_data), .pc_we(pc_we),
        .pc_out(pc_out), .sp(sp), .instruction_pointer(instruction_pointer),
        .system_mode_register(system_mode_register), .pmem_re(pmem_re), .pmem_addr(pmem_addr),
        .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
        .stack_wdata(stack_wdata), .flags_we(flags_we), .int_service(int_service));
    // memories answer to the registered address in the same cycle
    assign pmem_rdata = pmem_re ? (pmem_addr[7:0] ^ 8'h5a) : 8'hee;
    assign stack_rdata = stack_re ? stack_mem[stack_addr[7:0]] : 8'hee;
    always @(posedge clock) begin
        if (stack_we === 1'b1) stack_mem[stack_addr[7:0]] <= stack_wdata;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic run_op(input logic [7:0] op, input logic [7:0] opnd);
        @(posedge clock);
        op_valid <= 1'b1;
        opcode <= op;
        operand <= opnd;
        got_pair = 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            op_valid <= 1'b0;
            #1;
            n++;
            if (pair_we === 1'b1) {got_pair, seen_even, seen_odd} = {1'b1, pair_even_data, pair_odd_data};
            if (reg_we === 1'b1) seen_reg = reg_wdata;
        end while (done !== 1'b1 && n < 40);
        check(done, 1'b1);
    endtask
    task automatic div_one(input logic [7:0] op, input logic [15:0] dvd, input logic [7:0] dvs,
            input logic [7:0] e_even, input logic [7:0] e_odd, input logic e_pair);
        @(posedge clock);
        div_dividend <= dvd;
        div_divisor <= dvs;
        run_op(op, 8'h00);
        check(got_pair, e_pair);
        if (e_pair) check({seen_even, seen_odd}, {e_even, e_odd});
    endtask
    task automatic test_divide();
        div_one(lbt_pkg::OP_DIV_R, 16'h1003, 8'h40, 8'h03, 8'h40, 1'b1);
        div_one(lbt_pkg::OP_DIV_IR, 16'h1003, 8'h80, 8'h03, 8'h20, 1'b1);
        div_one(lbt_pkg::OP_DIV_IM, 16'h1003, 8'h20, 8'h03, 8'h80, 1'b1);
        div_one(lbt_pkg::OP_DIV_R, 16'hfe00, 8'hff, 8'hfe, 8'hfe, 1'b1);
        div_one(lbt_pkg::OP_DIV_R, 16'h1003, 8'h00, 8'h00, 8'h00, 1'b0);
    endtask
    task automatic loop_one(input logic [3:0] r, input logic [7:0] val, input logic [7:0] d,
            input logic [15:0] e_pc);
        @(posedge clock);
        loop_reg_val <= val;
        pc_in <= 16'h0100;
        run_op({r, lbt_pkg::OP_LOOP_LOW}, d);
        check(n[15:0], 16'h0008);
        check(seen_reg, 8'(val - 8'h01));
        check(reg_waddr, r);
        check(pc_out, e_pc);
        check(flags_we, 1'b0);
    endtask
    task automatic test_loop();
        loop_one(4'h1, 8'h02, 8'h7f, 16'h0181);
        loop_one(4'hc, 8'h00, 8'h80, 16'h0082);
        loop_one(4'hf, 8'h01, 8'h10, 16'h0102);
    endtask
    task automatic test_int();
        @(posedge clock);
        int_pending <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(int_service, 1'b0);
        run_op(lbt_pkg::OP_INT_EN, 8'h00);
        check(system_mode_register, 8'h01);
        @(posedge clock);
        #1;
        check(int_service, 1'b1);
        int_pending <= 1'b0;
    endtask
    task automatic test_thread();
        @(posedge clock);
        pc_in <= 16'h1234;
        run_op(lbt_pkg::OP_ENTER, 8'h00);
        check(n[15:0], 16'h0005);
        check(sp, 16'hfffe);
        check(instruction_pointer, 16'h1236);
        check(pc_out, 16'h6e6f);
        @(posedge clock);
        pc_in <= 16'h2000;
        run_op(lbt_pkg::OP_ENTER, 8'h00);
        check({stack_mem[8'hfc], stack_mem[8'hfd]}, 16'h1236);
        check(pc_out, 16'h5a5b);
        run_op(lbt_pkg::OP_EXIT, 8'h00);
        check(sp, 16'hfffe);
        check(instruction_pointer, 16'h1238);
        check(pc_out, 16'h6c6d);
        check(flags_we, 1'b0);
    endtask
    task automatic test_freeze();
        @(posedge clock);
        clk_en <= 1'b0;
        op_valid <= 1'b1;
        opcode <= lbt_pkg::OP_ENTER;
        repeat (3) @(posedge clock);
        #1;
        check(busy, 1'b0);
        check(sp, 16'hfffe);
        @(posedge clock);
        op_valid <= 1'b0;
        clk_en <= 1'b1;
        @(posedge clock);
        #1;
        check(busy, 1'b0);
        check(sp, 16'hfffe);
    endtask
    task automatic complete_run();
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        test_divide();
        test_loop();
        test_int();
        test_thread();
        test_freeze();
        complete_run();
    end
    initial begin
        #200000;
        num_errors++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        complete_run();
    end
endmodule
bind lbt_exec lbt_exec_monitor mon (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .op_valid(op_valid), .opcode(opcode), .operand(operand), .pc_in(pc_in),
    .div_dividend(div_dividend), .div_divisor(div_divisor), .loop_reg_val(loop_reg_val),
    .int_pending(int_pending), .busy(busy), .done(done), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .pair_we(pair_we), .pair_even_data(pair_even_data),
    .pair_odd_data(pair_odd_data), .pc_we(pc_we), .pc_out(pc_out), .sp(sp),
    .instruction_pointer(instruction_pointer), .system_mode_register(system_mode_register),
    .pmem_re(pmem_re), .pmem_addr(pmem_addr), .stack_we(stack_we), .flags_we(flags_we),
    .int_service(int_service));
